// ===== verilog/pol_seq_pkg.sv
// Shared constants and types for the output sequencing supervisor.
// Assumes a single 20 MHz clock and voltages carried as unsigned millivolt counts.
package pol_seq_pkg;

  localparam int VW = 16;
  localparam int AW = 8;

  // Clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;

  // Register offsets, byte addresses
  localparam logic [AW-1:0] A_OPERATION = 8'h00;
  localparam logic [AW-1:0] A_ONOFF_POLICY = 8'h04;
  localparam logic [AW-1:0] A_OUT_FORMAT = 8'h08;
  localparam logic [AW-1:0] A_OUT_TARGET = 8'h0c;
  localparam logic [AW-1:0] A_OUT_CEILING = 8'h10;
  localparam logic [AW-1:0] A_OUT_TRIM = 8'h14;
  localparam logic [AW-1:0] A_MARGIN_UP = 8'h18;
  localparam logic [AW-1:0] A_MARGIN_DOWN = 8'h1c;
  localparam logic [AW-1:0] A_SLEW_RATE = 8'h20;
  localparam logic [AW-1:0] A_CUR_GAIN = 8'h24;
  localparam logic [AW-1:0] A_CUR_ZERO = 8'h28;
  localparam logic [AW-1:0] A_RISE_DELAY = 8'h2c;
  localparam logic [AW-1:0] A_RISE_TIME = 8'h30;
  localparam logic [AW-1:0] A_RISE_LIMIT = 8'h34;
  localparam logic [AW-1:0] A_RISE_ACTION = 8'h38;
  localparam logic [AW-1:0] A_FALL_DELAY = 8'h3c;
  localparam logic [AW-1:0] A_FALL_TIME = 8'h40;
  localparam logic [AW-1:0] A_FALL_LIMIT = 8'h44;
  localparam logic [AW-1:0] A_FALL_ACTION = 8'h48;
  localparam logic [AW-1:0] A_GOOD_ON = 8'h4c;
  localparam logic [AW-1:0] A_GOOD_OFF = 8'h50;
  localparam logic [AW-1:0] A_GOOD_POLARITY = 8'h54;
  localparam logic [AW-1:0] A_SUPPLY_ON = 8'h58;
  localparam logic [AW-1:0] A_SUPPLY_OFF = 8'h5c;
  localparam logic [AW-1:0] A_SUPPLY_WARN = 8'h60;
  localparam logic [AW-1:0] A_SUPPLY_FAULT = 8'h64;
  localparam logic [AW-1:0] A_SUPPLY_ACTION = 8'h68;
  localparam logic [AW-1:0] A_STATUS = 8'h6c;
  localparam logic [AW-1:0] A_CUR_TOTAL = 8'h70;
  localparam logic [AW-1:0] A_CUR_PHASE0 = 8'h74;
  localparam logic [AW-1:0] A_CUR_PHASE1 = 8'h78;
  localparam logic [AW-1:0] A_REF_NOW = 8'h7c;

  // Operation byte fields
  localparam int OP_ON_BIT = 7;
  localparam int OP_MARGIN_LSB = 4;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;

  // On/off policy bits
  localparam int POL_USE_OP = 0;
  localparam int POL_USE_PIN = 1;

  // Reset values
  localparam logic [7:0] OPERATION_RST = 8'h00;
  localparam logic [1:0] POLICY_RST = 2'h2;
  localparam logic [VW-1:0] CEILING_RST = 16'hffff;
  localparam logic [VW-1:0] GOOD_POL_RST = 16'h0001;

  // Status bit positions
  localparam int ST_RISE_FAULT = 0;
  localparam int ST_FALL_FAULT = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_PREBIAS_SLOW = 3;
  localparam int ST_SUPPLY_WARN = 4;
  localparam int ST_SUPPLY_FAULT = 5;
  localparam int ST_STICKY = 6;
  localparam int ST_SUPPLY_OK = 6;
  localparam int ST_GOOD = 7;
  localparam int ST_STATE_LSB = 8;

  // Pre-bias thresholds and times
  localparam logic [VW-1:0] PREBIAS_MIN_MV = 16'd300;
  localparam logic [VW-1:0] PREBIAS_MAX_MV = 16'd3650;
  localparam logic [VW-1:0] PREBIAS_SETTLE_MS = 16'd50;

  typedef struct packed {
    logic [2:0] mode;
    logic [4:0] exponent;
  } vout_format_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [VW-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ON_DELAY = 3'h1,
    S_RAMP_UP = 3'h3,
    S_REGULATE = 3'h2,
    S_OFF_DELAY = 3'h6,
    S_RAMP_DOWN = 3'h7,
    S_FAULT_OFF = 3'h5
  } seq_state_t;

endpackage

// ===== verilog/pol_output_sequencing_supervisor.sv
// Output sequencing and supervision for a dual-phase point-of-load controller.
// Assumes measurements arrive on clk already converted; only the control pin is asynchronous.
// Behaviour
// - Converter runs while pin high and operation bit 7 set, each required only where the policy bit selects it.
// - Output format byte holds 3-bit mode and 5-bit exponent.
// - Target writes above the ceiling are dropped; old target stays.
// - Trim offset added to every target, changeable while running.
// - Margin high or low selects the matching margin voltage.
// - Margin moves ramp linearly at the programmed slew rate.
// - Phase current is sense over gain minus zero; total is both phases.
// - Output below 300 mV at enable gives a normal delayed soft start.
// - Output above 3.65 V at enable refuses start, switching stays off.
// - Pre-bias above target: overvoltage off, duty preload, rearm below ceiling.
// - Pre-bias below target: undervoltage off, duty preload, rearm above low limit.
// - Pre-biased start must regulate within 50 ms.
// - Turn-on and turn-off delays precede rise and fall.
// - Soft-start ramp reaches the band in the rise time.
// - Rise limit missed flags undervoltage fault and applies rise action.
// - Soft-stop ramp reaches zero in the fall time.
// - Fall limit missed with output above 0 V flags overvoltage fault.
// - Missed rise or fall criteria set output status bits.
// - Power good on at on-level, off at off-level or on leaving regulation, within 1 ms.
// - Polarity byte 0 gives active low power good, 1 active high.
// - Conversion allowed above supply-on, stopped below supply-off.
// - Supply warning and fault flags; fault applies two-bit action.
`timescale 1ns/1ps
module pol_output_sequencing_supervisor
  import pol_seq_pkg::*;
#(
  parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire reg_req_t regReq,
  output logic [VW-1:0] regRdata,
  // Control pin from host
  input wire logic converter_enable_pin,
  // Measurements on clk
  input wire logic [VW-1:0] vOutMeas,
  input wire logic [VW-1:0] vInMeas,
  input wire logic [VW-1:0] senseVolt0,
  input wire logic [VW-1:0] senseVolt1,
  // Converter controls
  output logic switchEnable,
  output logic ovpEnable,
  output logic uvpEnable,
  output logic dutyLoad,
  output logic [VW-1:0] dutyPreload,
  output logic [VW-1:0] vRef,
  output logic [VW-1:0] iTotal,
  // Status pin
  output logic power_ok_output
);

  localparam int MSW = $clog2(MS_CYCLES + 1);
  if (MS_CYCLES < 2) begin : g_bad_tick
    $error("MS_CYCLES must be at least 2");
  end

  seq_state_t state;
  logic [7:0] operation;
  logic [1:0] policy;
  vout_format_t outFormat;
  logic [VW-1:0] outTarget, outCeiling, outTrim, marginUp, marginDown, slewRate;
  logic [VW-1:0] curGain, curZero, riseDelay, riseTime, riseLimit, fallDelay, fallTime, fallLimit;
  logic [1:0] riseAction, fallAction, supplyAction;
  logic [VW-1:0] goodOn, goodOff, goodPolarity, supplyOn, supplyOff, supplyWarn, supplyFault;
  logic [ST_STICKY-1:0] sticky;
  logic [VW-1:0] iPhase0, iPhase1;
  logic pinS1, pinS2, pinS3, pinLevel;
  logic [MSW-1:0] msCount;
  logic msTick;
  logic [VW-1:0] phaseMs, runMs, settleMs, stepUp, stepDown;
  logic prebias, settleRun, supplyOk, goodActive;

  // Control pin: three stages, level moves only when the last two agree
  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1 <= 1'b0;
      pinS2 <= 1'b0;
      pinS3 <= 1'b0;
      pinLevel <= 1'b0;
    end else begin
      pinS1 <= converter_enable_pin;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      if (pinS2 == pinS3) begin
        pinLevel <= pinS3;
      end
    end
  end

  // Millisecond time base
  always_ff @(posedge clk) begin
    if (rst) begin
      msCount <= '0;
      msTick <= 1'b0;
    end else begin
      msTick <= (msCount == MSW'(MS_CYCLES - 1));
      msCount <= (msCount == MSW'(MS_CYCLES - 1)) ? '0 : msCount + 1'b1;
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      operation <= OPERATION_RST;
      policy <= POLICY_RST;
      outFormat <= '0;
      outTarget <= '0;
      outCeiling <= CEILING_RST;
      outTrim <= '0;
      marginUp <= '0;
      marginDown <= '0;
      slewRate <= '0;
      curGain <= '0;
      curZero <= '0;
      riseDelay <= '0;
      riseTime <= '0;
      riseLimit <= '0;
      riseAction <= '0;
      fallDelay <= '0;
      fallTime <= '0;
      fallLimit <= '0;
      fallAction <= '0;
      goodOn <= '0;
      goodOff <= '0;
      goodPolarity <= GOOD_POL_RST;
      supplyOn <= '0;
      supplyOff <= '0;
      supplyWarn <= '0;
      supplyFault <= '0;
      supplyAction <= '0;
    end else if (regReq.wr) begin
      case (regReq.addr)
        A_OPERATION: operation <= regReq.wdata[7:0];
        A_ONOFF_POLICY: policy <= regReq.wdata[1:0];
        A_OUT_FORMAT: outFormat <= regReq.wdata[7:0];
        A_OUT_TARGET: begin
          if (regReq.wdata <= outCeiling) begin
            outTarget <= regReq.wdata;
          end
        end
        A_OUT_CEILING: outCeiling <= regReq.wdata;
        A_OUT_TRIM: outTrim <= regReq.wdata;
        A_MARGIN_UP: marginUp <= regReq.wdata;
        A_MARGIN_DOWN: marginDown <= regReq.wdata;
        A_SLEW_RATE: slewRate <= regReq.wdata;
        A_CUR_GAIN: curGain <= regReq.wdata;
        A_CUR_ZERO: curZero <= regReq.wdata;
        A_RISE_DELAY: riseDelay <= regReq.wdata;
        A_RISE_TIME: riseTime <= regReq.wdata;
        A_RISE_LIMIT: riseLimit <= regReq.wdata;
        A_RISE_ACTION: riseAction <= regReq.wdata[1:0];
        A_FALL_DELAY: fallDelay <= regReq.wdata;
        A_FALL_TIME: fallTime <= regReq.wdata;
        A_FALL_LIMIT: fallLimit <= regReq.wdata;
        A_FALL_ACTION: fallAction <= regReq.wdata[1:0];
        A_GOOD_ON: goodOn <= regReq.wdata;
        A_GOOD_OFF: goodOff <= regReq.wdata;
        A_GOOD_POLARITY: goodPolarity <= regReq.wdata;
        A_SUPPLY_ON: supplyOn <= regReq.wdata;
        A_SUPPLY_OFF: supplyOff <= regReq.wdata;
        A_SUPPLY_WARN: supplyWarn <= regReq.wdata;
        A_SUPPLY_FAULT: supplyFault <= regReq.wdata;
        A_SUPPLY_ACTION: supplyAction <= regReq.wdata[1:0];
        default: ;
      endcase
    end
  end

  // Derived control terms
  logic demand, wantOn, inBand, riseExpired, fallExpired, refuse, settleMiss, supplyTrip;
  logic [VW-1:0] target, goal;
  logic [2*VW-1:0] ratio;
  assign demand = (!policy[POL_USE_PIN] || pinLevel) && (!policy[POL_USE_OP] || operation[OP_ON_BIT]);
  assign wantOn = demand && supplyOk;
  assign target = (operation[OP_MARGIN_LSB +: 2] == MARGIN_HIGH) ? marginUp :
                  (operation[OP_MARGIN_LSB +: 2] == MARGIN_LOW) ? marginDown : outTarget;
  assign goal = VW'(target + outTrim);
  assign inBand = vOutMeas >= goodOn;
  assign riseExpired = (state == S_ON_DELAY || state == S_RAMP_UP) && riseLimit != '0 && runMs >= riseLimit;
  assign fallExpired = (state == S_OFF_DELAY || state == S_RAMP_DOWN) && fallLimit != '0 &&
                       runMs >= fallLimit && vOutMeas != '0;
  assign refuse = state == S_IDLE && wantOn && vOutMeas > PREBIAS_MAX_MV;
  assign settleMiss = settleRun && settleMs == PREBIAS_SETTLE_MS && !inBand;
  assign supplyTrip = vInMeas < supplyFault && supplyAction != '0 && state != S_IDLE && state != S_FAULT_OFF;
  assign ratio = (vInMeas == '0) ? '1 : {vOutMeas, {VW{1'b0}}} / {{VW{1'b0}}, vInMeas};

  // Sequencer with its ramps and timers
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      vRef <= '0;
      phaseMs <= '0;
      runMs <= '0;
      stepUp <= '0;
      stepDown <= '0;
      prebias <= 1'b0;
      dutyLoad <= 1'b0;
      dutyPreload <= '0;
    end else begin
      dutyLoad <= 1'b0;
      if (msTick && phaseMs != '1) begin
        phaseMs <= phaseMs + 1'b1;
      end
      if (msTick && runMs != '1) begin
        runMs <= runMs + 1'b1;
      end
      if ((riseExpired && riseAction != '0) || (fallExpired && fallAction != '0) || supplyTrip) begin
        state <= S_FAULT_OFF;
        vRef <= '0;
      end else begin
        case (state)
          S_IDLE: begin
            vRef <= '0;
            if (wantOn && !refuse) begin
              state <= S_ON_DELAY;
              prebias <= vOutMeas >= PREBIAS_MIN_MV;
              phaseMs <= '0;
              runMs <= '0;
            end
          end
          S_ON_DELAY: begin
            if (!wantOn) begin
              state <= S_IDLE;
            end else if (phaseMs >= riseDelay) begin
              phaseMs <= '0;
              if (prebias) begin
                state <= S_REGULATE;
                vRef <= vOutMeas;
                dutyLoad <= 1'b1;
                dutyPreload <= (ratio[2*VW-1:VW] != '0) ? '1 : ratio[VW-1:0];
              end else begin
                state <= S_RAMP_UP;
                vRef <= '0;
                stepUp <= (riseTime == '0) ? goal : ((goal / riseTime) == '0 ? 16'h0001 : goal / riseTime);
              end
            end
          end
          S_RAMP_UP: begin
            if (!wantOn) begin
              state <= S_OFF_DELAY;
              phaseMs <= '0;
              runMs <= '0;
            end else if (vRef >= goal) begin
              state <= S_REGULATE;
            end else if (msTick) begin
              vRef <= (goal - vRef > stepUp) ? vRef + stepUp : goal;
            end
          end
          S_REGULATE: begin
            if (!wantOn) begin
              state <= S_OFF_DELAY;
              phaseMs <= '0;
              runMs <= '0;
            end else if (msTick || slewRate == '0) begin
              // Zero slew rate means a step rather than a stall
              if (vRef < goal) begin
                vRef <= (slewRate == '0 || goal - vRef <= slewRate) ? goal : vRef + slewRate;
              end else if (vRef > goal) begin
                vRef <= (slewRate == '0 || vRef - goal <= slewRate) ? goal : vRef - slewRate;
              end
            end
          end
          S_OFF_DELAY: begin
            if (wantOn) begin
              state <= S_REGULATE;
            end else if (phaseMs >= fallDelay) begin
              state <= S_RAMP_DOWN;
              stepDown <= (fallTime == '0) ? vRef : ((vRef / fallTime) == '0 ? 16'h0001 : vRef / fallTime);
            end
          end
          S_RAMP_DOWN: begin
            if (vRef == '0 && (vOutMeas == '0 || fallLimit == '0 || fallAction == '0)) begin
              state <= S_IDLE;
            end else if (msTick) begin
              vRef <= (vRef > stepDown) ? vRef - stepDown : '0;
            end
          end
          S_FAULT_OFF: begin
            vRef <= '0;
            if (!demand) begin
              state <= S_IDLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Pre-bias protection masking and settle timer
  always_ff @(posedge clk) begin
    if (rst) begin
      ovpEnable <= 1'b1;
      uvpEnable <= 1'b1;
      settleRun <= 1'b0;
      settleMs <= '0;
    end else if (state == S_IDLE || state == S_FAULT_OFF) begin
      ovpEnable <= 1'b1;
      uvpEnable <= 1'b1;
      settleRun <= 1'b0;
    end else if (state == S_ON_DELAY && prebias && wantOn && phaseMs >= riseDelay && !supplyTrip) begin
      ovpEnable <= !(vOutMeas > goal);
      uvpEnable <= !(vOutMeas < goal);
      settleRun <= 1'b1;
      settleMs <= '0;
    end else begin
      if (!ovpEnable && vOutMeas < outCeiling) begin
        ovpEnable <= 1'b1;
      end
      if (!uvpEnable && vOutMeas > goodOff) begin
        uvpEnable <= 1'b1;
      end
      if (settleRun && (inBand || settleMs == PREBIAS_SETTLE_MS)) begin
        settleRun <= 1'b0;
      end else if (settleRun && msTick) begin
        settleMs <= settleMs + 1'b1;
      end
    end
  end

  // Supply hysteresis
  always_ff @(posedge clk) begin
    if (rst) begin
      supplyOk <= 1'b0;
    end else if (vInMeas < supplyOff) begin
      supplyOk <= 1'b0;
    end else if (vInMeas >= supplyOn) begin
      supplyOk <= 1'b1;
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  logic [ST_STICKY-1:0] stickySet, stickyClr;
  assign stickySet = {vInMeas < supplyFault, vInMeas < supplyWarn, settleMiss, refuse, fallExpired, riseExpired};
  assign stickyClr = (regReq.wr && regReq.addr == A_STATUS) ? regReq.wdata[ST_STICKY-1:0] : '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      sticky <= '0;
    end else begin
      sticky <= (sticky & ~stickyClr) | stickySet;
    end
  end

  // Power good and its pin
  logic polHigh, goodPin;
  assign polHigh = goodPolarity[7:0] != 8'h00;
  assign goodPin = polHigh ? goodActive : !goodActive;
  always_ff @(posedge clk) begin
    if (rst) begin
      goodActive <= 1'b0;
      power_ok_output <= 1'b0;
      switchEnable <= 1'b0;
    end else begin
      if (state != S_REGULATE) begin
        goodActive <= 1'b0;
      end else if (goodActive) begin
        goodActive <= vOutMeas >= goodOff;
      end else begin
        goodActive <= vOutMeas >= goodOn;
      end
      power_ok_output <= goodPin;
      switchEnable <= state == S_RAMP_UP || state == S_REGULATE || state == S_OFF_DELAY || state == S_RAMP_DOWN;
    end
  end

  // Current reporting
  logic [VW-1:0] raw0, raw1;
  assign raw0 = (curGain == '0) ? senseVolt0 : senseVolt0 / curGain;
  assign raw1 = (curGain == '0) ? senseVolt1 : senseVolt1 / curGain;
  always_ff @(posedge clk) begin
    if (rst) begin
      iPhase0 <= '0;
      iPhase1 <= '0;
      iTotal <= '0;
    end else begin
      iPhase0 <= VW'(raw0 - curZero);
      iPhase1 <= VW'(raw1 - curZero);
      iTotal <= VW'(iPhase0 + iPhase1);
    end
  end

  // Read data, valid only in the cycle after the strobe
  logic [VW-1:0] readMux;
  always_comb begin
    readMux = '0;
    case (regReq.addr)
      A_OPERATION: readMux = {8'h00, operation};
      A_ONOFF_POLICY: readMux = {14'h0000, policy};
      A_OUT_FORMAT: readMux = {8'h00, outFormat};
      A_OUT_TARGET: readMux = outTarget;
      A_OUT_CEILING: readMux = outCeiling;
      A_OUT_TRIM: readMux = outTrim;
      A_MARGIN_UP: readMux = marginUp;
      A_MARGIN_DOWN: readMux = marginDown;
      A_SLEW_RATE: readMux = slewRate;
      A_CUR_GAIN: readMux = curGain;
      A_CUR_ZERO: readMux = curZero;
      A_RISE_DELAY: readMux = riseDelay;
      A_RISE_TIME: readMux = riseTime;
      A_RISE_LIMIT: readMux = riseLimit;
      A_RISE_ACTION: readMux = {14'h0000, riseAction};
      A_FALL_DELAY: readMux = fallDelay;
      A_FALL_TIME: readMux = fallTime;
      A_FALL_LIMIT: readMux = fallLimit;
      A_FALL_ACTION: readMux = {14'h0000, fallAction};
      A_GOOD_ON: readMux = goodOn;
      A_GOOD_OFF: readMux = goodOff;
      A_GOOD_POLARITY: readMux = goodPolarity;
      A_SUPPLY_ON: readMux = supplyOn;
      A_SUPPLY_OFF: readMux = supplyOff;
      A_SUPPLY_WARN: readMux = supplyWarn;
      A_SUPPLY_FAULT: readMux = supplyFault;
      A_SUPPLY_ACTION: readMux = {14'h0000, supplyAction};
      A_STATUS: readMux = {5'h00, state, goodActive, supplyOk, sticky};
      A_CUR_TOTAL: readMux = iTotal;
      A_CUR_PHASE0: readMux = iPhase0;
      A_CUR_PHASE1: readMux = iPhase1;
      A_REF_NOW: readMux = vRef;
      default: readMux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regReq.rd ? readMux : '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sPrebiasGo;
    state == S_ON_DELAY && prebias && wantOn && phaseMs >= riseDelay && !supplyTrip &&
    !(riseExpired && riseAction != '0);
  endsequence
  sequence sFallMiss;
    fallExpired && fallAction != '0;
  endsequence

  refuse_start_a: assert property (refuse && !supplyTrip |=> state == S_IDLE ##1 !switchEnable)
    else $error("start not refused on high output");
  target_guard_a: assert property (regReq.wr && regReq.addr == A_OUT_TARGET && regReq.wdata > outCeiling
    |=> outTarget == $past(outTarget))
    else $error("target above ceiling accepted");
  normal_start_a: assert property (state == S_IDLE && wantOn && vOutMeas < PREBIAS_MIN_MV
    |=> state == S_ON_DELAY && !prebias)
    else $error("normal start path not taken");
  prebias_entry_a: assert property (sPrebiasGo |=> state == S_REGULATE && dutyLoad && settleRun)
    else $error("pre-bias start did not skip soft start");
  rise_fault_a: assert property (riseExpired |=> sticky[ST_RISE_FAULT])
    else $error("rise limit miss not flagged");
  fall_fault_a: assert property (sFallMiss |=> state == S_FAULT_OFF && sticky[ST_FALL_FAULT])
    else $error("fall limit miss not handled");
  good_drop_a: assert property (state != S_REGULATE |=> !goodActive ##1 power_ok_output == $past(polHigh, 1) ^ 1'b1
    || $past(polHigh, 1) != polHigh)
    else $error("power good not dropped on ramp down");
  good_polarity_a: assert property (1'b1 |=> power_ok_output == ((($past(goodPolarity) & 16'h00ff) != 16'h0000) ?
    $past(goodActive) : !$past(goodActive)))
    else $error("power good polarity wrong");
  supply_off_a: assert property (vInMeas < supplyOff |=> !supplyOk && !wantOn)
    else $error("supply off level ignored");
  trim_step_a: assert property (state == S_REGULATE && wantOn && slewRate == '0 && !supplyTrip
    |=> vRef == $past(goal))
    else $error("trim not applied to reference");
  pin_filter_a: assert property (pinS2 != pinS3 |=> pinLevel == $past(pinLevel))
    else $error("pin level moved on disagreement");

endmodule

// ===== testbench/output_stage_model.sv
// Behavioural output stage behind the supervisor.
// Assumes vRef in mV; a bias stands for charge left on the output.
`timescale 1ns/1ps
module output_stage_model (
  // Clock
  input wire logic clk,
  // From the supervisor
  input wire logic switchEnable,
  input wire logic [15:0] vRef,
  // Bench control
  input wire logic [15:0] bias,
  // Measurement back to the supervisor
  output logic [15:0] vOutMeas
);
  // Settles in one cycle; slow plants would hide ramp faults
  always_ff @(posedge clk) begin
    vOutMeas <= switchEnable ? vRef : bias;
  end
endmodule

// ===== testbench/pol_output_sequencing_supervisor_test.sv
// Self-checking bench for the output sequencing supervisor.
// Assumes the output stage model closes the loop on vOutMeas.
`timescale 1ns/1ps
module pol_output_sequencing_supervisor_test;
  import pol_seq_pkg::*;
  logic clk = 0, rst = 1, pin = 0, swEn, ovp, uvp, dLoad, pOk;
  reg_req_t regReq = '0;
  logic [15:0] rdata, vOut, bias = 0, s0 = 10, s1 = 20, duty, vRef, iTot, v, vIn = 16'h1388;
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #25 clk = ~clk;
  output_stage_model output_stage_model_i (.clk(clk), .switchEnable(swEn), .vRef(vRef), .bias(bias),
    .vOutMeas(vOut));
  pol_output_sequencing_supervisor #(.MS_CYCLES(20)) pol_output_sequencing_supervisor_i (.clk(clk),
    .rst(rst), .regReq(regReq), .regRdata(rdata), .converter_enable_pin(pin), .vOutMeas(vOut),
    .vInMeas(vIn), .senseVolt0(s0), .senseVolt1(s1), .switchEnable(swEn), .ovpEnable(ovp),
    .uvpEnable(uvp), .dutyLoad(dLoad), .dutyPreload(duty), .vRef(vRef), .iTotal(iTot),
    .power_ok_output(pOk));
  task close_out;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard well above the longest sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out;
    end
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (exp !== got) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) regReq.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) regReq <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) regReq.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task t_reset;
    rd(A_OUT_CEILING, v); chk("ceiling", 16'hffff, v);
    rd(A_GOOD_POLARITY, v); chk("polarity", 16'h0001, v);
    rd(8'h80, v); chk("unmapped", 16'h0000, v);
    chk("ovp", 16'h0001, {15'h0, ovp});
    $display("test reset done");
  endtask
  task t_limit;
    wr(A_OUT_CEILING, 16'h03e8);
    wr(A_OUT_TARGET, 16'h03e9);
    rd(A_OUT_TARGET, v); chk("target over", 16'h0000, v);
    wr(A_OUT_TARGET, 16'h0320);
    rd(A_OUT_TARGET, v); chk("target", 16'h0320, v);
    wr(A_OUT_FORMAT, 16'h00b7);
    rd(A_OUT_FORMAT, v); chk("format", 16'h00b7, v);
    $display("test limit done");
  endtask
  task t_current;
    wr(A_CUR_GAIN, 16'h0002);
    wr(A_CUR_ZERO, 16'h0001);
    repeat (4) @(posedge clk);
    #1 chk("iTotal", 16'h000d, iTot);
    rd(A_CUR_PHASE1, v); chk("phase1", 16'h0009, v);
    $display("test current done");
  endtask
  task t_refuse;
    @(posedge clk) bias <= 16'h0fa0;
    pin <= 1'b1;
    repeat (60) @(posedge clk);
    chk("refused switch", 16'h0000, {15'h0, swEn});
    rd(A_STATUS, v); chk("refused bit", 16'h0001, {15'h0, v[ST_REFUSED]});
    @(posedge clk) pin <= 1'b0;
    bias <= 16'h0000;
    repeat (8) @(posedge clk);
    wr(A_STATUS, 16'h0004);
    rd(A_STATUS, v); chk("refused clear", 16'h0000, {15'h0, v[ST_REFUSED]});
    $display("test refuse done");
  endtask
  task t_start;
    wr(A_RISE_DELAY, 16'h0002);
    wr(A_RISE_TIME, 16'h0001);
    wr(A_GOOD_ON, 16'h01f4);
    wr(A_OUT_TRIM, 16'h0004);
    @(posedge clk) pin <= 1'b1;
    repeat (20) @(posedge clk);
    chk("in on delay", 16'h0000, {15'h0, swEn});
    for (int i = 0; i < 400 && pOk !== 1'b1; i++) @(posedge clk);
    chk("good on", 16'h0001, {15'h0, pOk});
    repeat (60) @(posedge clk);
    chk("vRef trim", 16'h0324, vRef);
    @(posedge clk) pin <= 1'b0;
    for (int i = 0; i < 400 && pOk !== 1'b0; i++) @(posedge clk);
    chk("good off", 16'h0000, {15'h0, pOk});
    $display("test start stop done");
  endtask
  task t_prebias;
    @(posedge clk) bias <= 16'h0258;
    repeat (40) @(posedge clk);
    pin <= 1'b1;
    wait (dLoad === 1'b1);
    #1 chk("duty preload", 16'h1eb8, duty);
    chk("uvp masked", 16'h0000, {15'h0, uvp});
    chk("ovp kept", 16'h0001, {15'h0, ovp});
    repeat (60) @(posedge clk);
    chk("uvp rearmed", 16'h0001, {15'h0, uvp});
    chk("regulated", 16'h0324, vRef);
    $display("test prebias done");
  endtask
  task t_margin;
    wr(A_SLEW_RATE, 16'h0064);
    wr(A_MARGIN_UP, 16'h04b0);
    wr(A_OPERATION, 16'h0020);
    wait (vRef != 16'h0324);
    #1 chk("slew step", 16'h0388, vRef);
    repeat (100) @(posedge clk);
    chk("margin high", 16'h04b4, vRef);
    wr(A_GOOD_POLARITY, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk("good active low", 16'h0000, {15'h0, pOk});
    wr(A_GOOD_POLARITY, 16'h0001);
    $display("test margin done");
  endtask
  task t_supply;
    wr(A_SUPPLY_OFF, 16'h1000);
    wr(A_SUPPLY_WARN, 16'h1000);
    @(posedge clk) vIn <= 16'h0fa0;
    for (int i = 0; i < 400 && pOk !== 1'b0; i++) @(posedge clk);
    chk("supply off", 16'h0000, {15'h0, pOk});
    rd(A_STATUS, v); chk("supply flags", 16'h0001, {13'h0, v[6:4]});
    @(posedge clk) pin <= 1'b0;
    vIn <= 16'h1388;
    repeat (8) @(posedge clk);
    $display("test supply done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_limit;
    t_current;
    t_refuse;
    t_start;
    t_prebias;
    t_margin;
    t_supply;
    close_out;
  end
endmodule
